//--- csrs_top.sv
// What this block does
// RULE1 - Doubler on: internal clock twice source
// RULE2 - Doubler off: internal clock is source/2
// RULE3 - Doubler enabled only by configuration option
// RULE4 - Never configure doubler with RC oscillator
// RULE5 - Clock source chosen by configuration option
// RULE6 - Crystal oscillator keeps running during reset
// RULE7 - Pin, low-voltage and watchdog resets accepted
// RULE8 - Reset pin low throughout stabilisation delay
// RULE9 - Vector fetched from FFFE and FFFF
// RULE10 - Active, delay, fetch phases in order
// RULE11 - Delay is 256 or 4096 cycles
// RULE12 - Vector fetch lasts exactly two cycles
// RULE13 - Reset pin is input and open-drain output
// RULE14 - External reset caught without running clock
// RULE15 - External pulse must meet minimum width
// RULE16 - Pick delay to suit oscillator start-up
// RULE17 - Watchdog drives pin low minimum duration
// RULE18 - Low-voltage reset holds pin low
// RULE19 - Source release synchronised before delay count
`timescale 1ns/1ps
`default_nettype none

module csrs_top
    import csrs_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst,
    // Configuration options.
    input  wire logic [2:0]  cfg_clk_source,
    input  wire logic        cfg_doubler_en,
    input  wire logic        cfg_long_delay,
    // Oscillator source clock enables and doubler output enable.
    input  wire logic        source_clock_tick,
    input  wire logic        doubler_clock_tick,
    output logic             internal_clock_en,
    output logic             doubler_active,
    output logic             osc_run,
    output logic [2:0]       osc_select,
    // Reset sources.
    input  wire logic        low_voltage_detector,
    input  wire logic        watchdog_underflow,
    // Open-drain reset pin.
    input  wire logic        reset_pin_in,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    // Reset outputs toward the core.
    output logic             core_reset,
    output logic             vector_fetch,
    output logic [15:0]      vector_addr,
    output logic [1:0]       reset_phase
);

    // ****************************************************************
    // Clock selection
    // ****************************************************************

    // Doubler follows only the static option and never the RC source.
    wire logic doubler_ok = cfg_doubler_en && (cfg_clk_source != CSRS_SRC_RC); // RULE3 RULE4

    logic div_toggle;

    // Divide-by-two of the source clock when the doubler is off.
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_toggle <= 1'b0;
        end else if (source_clock_tick) begin
            div_toggle <= ~div_toggle; // RULE2
        end
    end

    // Doubler output doubles the source; otherwise every second source tick.
    assign internal_clock_en = doubler_ok ? doubler_clock_tick               // RULE1
                                          : (source_clock_tick & div_toggle); // RULE2
    assign doubler_active = doubler_ok;
    assign osc_select     = cfg_clk_source; // RULE5
    assign osc_run        = 1'b1;           // RULE6

    // ****************************************************************
    // Reset source capture
    // ****************************************************************

    logic        pin_sync1;
    logic        pin_sync2;
    logic        ext_latched;
    logic        pin_drive;
    csrs_state_t state;
    logic [11:0] cnt;
    logic [11:0] wdg_cnt;

    // The pin reads back the device's own drive. Only a low level that the
    // device is not making itself counts as an external reset; otherwise the
    // delay phase would see its own pull and restart forever.
    wire logic pin_ext_low = !reset_pin_in && !pin_drive; // RULE13

    // The pin is sampled through two flops; the raw low level is also
    // latched so a short pulse is held until the sequencer sees it.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_sync1 <= 1'b1;
            pin_sync2 <= 1'b1;
        end else begin
            pin_sync1 <= !pin_ext_low;
            pin_sync2 <= pin_sync1; // RULE19
        end
    end

    // Latch an external low level directly from the pin, no sync needed.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_latched <= 1'b0;
        end else if (pin_ext_low) begin
            ext_latched <= 1'b1; // RULE14 RULE15
        end else if (state == CSRS_ACTIVE) begin
            ext_latched <= 1'b0;
        end
    end

    // Watchdog stretch counter keeps the pin low a minimum time.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wdg_cnt <= 12'h000;
        end else if (watchdog_underflow) begin
            wdg_cnt <= CSRS_WDG_LAST; // RULE17
        end else if (wdg_cnt != 12'h000) begin
            wdg_cnt <= wdg_cnt - 12'h001;
        end
    end

    wire logic wdg_hold   = watchdog_underflow || (wdg_cnt != 12'h000); // RULE17
    wire logic src_active = ext_latched || !pin_sync2 || low_voltage_detector
                            || wdg_hold; // RULE7

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************

    wire logic [11:0] delay_last = cfg_long_delay ? CSRS_LONG_LAST : CSRS_SHORT_LAST; // RULE11

    csrs_state_t next_state;
    logic [11:0] next_cnt;

    // Next-state logic: any source restarts the active phase.
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            CSRS_RUN: begin
                if (src_active) begin
                    next_state = CSRS_ACTIVE; // RULE10
                end
            end
            CSRS_ACTIVE: begin
                if (!src_active) begin
                    next_state = CSRS_DELAY; // RULE10 RULE19
                    next_cnt   = 12'h000;
                end
            end
            CSRS_DELAY: begin
                if (src_active) begin
                    next_state = CSRS_ACTIVE;
                end else if (cnt == delay_last) begin
                    next_state = CSRS_FETCH; // RULE11
                    next_cnt   = 12'h000;
                end else begin
                    next_cnt = cnt + 12'h001;
                end
            end
            CSRS_FETCH: begin
                if (src_active) begin
                    next_state = CSRS_ACTIVE;
                end else if (cnt == CSRS_FETCH_LAST) begin
                    next_state = CSRS_RUN; // RULE12
                end else begin
                    next_cnt = cnt + 12'h001;
                end
            end
        endcase
    end

    // State and counter registers; reset starts a full sequence.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= CSRS_ACTIVE;
            cnt   <= 12'h000;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    logic [15:0] vaddr;

    // Drive the pin low in the delay phase and while an internal source
    // is active, so other devices on the line are reset too.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_drive <= 1'b1;
        end else begin
            pin_drive <= (next_state == CSRS_DELAY)        // RULE8
                         || low_voltage_detector           // RULE18
                         || wdg_hold;                      // RULE17
        end
    end

    // Vector address register for the two fetch cycles.
    always_ff @(posedge mclk) begin
        if (rst) begin
            vaddr <= CSRS_VEC_LO;
        end else begin
            vaddr <= (next_state == CSRS_FETCH && next_cnt != 12'h000) ? CSRS_VEC_HI
                                                                       : CSRS_VEC_LO; // RULE9
        end
    end

    assign reset_pin_out = 1'b0;      // RULE13
    assign reset_pin_oe  = pin_drive; // RULE13
    assign core_reset    = (state != CSRS_RUN);
    assign vector_fetch  = (state == CSRS_FETCH); // RULE12
    assign vector_addr   = vaddr;
    assign reset_phase   = state;

endmodule

`default_nettype wire

//--- csrs_pkg.sv
package csrs_pkg;

    // ****************************************************************
    // Clock source selection codes
    // ****************************************************************
    localparam logic [2:0] CSRS_SRC_EXT   = 3'h0;
    localparam logic [2:0] CSRS_SRC_XTAL0 = 3'h1;
    localparam logic [2:0] CSRS_SRC_XTAL1 = 3'h2;
    localparam logic [2:0] CSRS_SRC_XTAL2 = 3'h3;
    localparam logic [2:0] CSRS_SRC_XTAL3 = 3'h4;
    localparam logic [2:0] CSRS_SRC_RC    = 3'h5;

    // ****************************************************************
    // Reset sequence timing in mclk cycles
    // ****************************************************************
    localparam int         CSRS_SHORT_DELAY  = 256;
    localparam int         CSRS_LONG_DELAY   = 4096;
    localparam int         CSRS_FETCH_CYCLES = 2;
    localparam int         CSRS_WDG_PULSE    = 16;
    localparam int         CSRS_CNT_W        = 12;
    localparam logic [11:0] CSRS_SHORT_LAST  = 12'(CSRS_SHORT_DELAY - 1);
    localparam logic [11:0] CSRS_LONG_LAST   = 12'(CSRS_LONG_DELAY - 1);
    localparam logic [11:0] CSRS_FETCH_LAST  = 12'(CSRS_FETCH_CYCLES - 1);
    localparam logic [11:0] CSRS_WDG_LAST    = 12'(CSRS_WDG_PULSE - 1);

    // ****************************************************************
    // Reset vector address pair
    // ****************************************************************
    localparam logic [15:0] CSRS_VEC_LO = 16'hFFFE;
    localparam logic [15:0] CSRS_VEC_HI = 16'hFFFF;

    // ****************************************************************
    // Sequencer states, Gray coded along the usual path
    // ****************************************************************
    typedef enum logic [1:0] {
        CSRS_RUN    = 2'h0,
        CSRS_ACTIVE = 2'h1,
        CSRS_DELAY  = 2'h3,
        CSRS_FETCH  = 2'h2
    } csrs_state_t;

endpackage

//--- csrs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Sequencer checks.
// ****
module csrs_monitor
    import csrs_pkg::*;
(
    // Clock, reset and options.
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [2:0]  cfg_clk_source,
    input wire logic        cfg_doubler_en,
    input wire logic        cfg_long_delay,
    // Clock path.
    input wire logic        doubler_active,
    input wire logic        osc_run,
    input wire logic [2:0]  osc_select,
    // Reset path.
    input wire logic        low_voltage_detector,
    input wire logic        watchdog_underflow,
    input wire logic        reset_pin_oe,
    input wire logic        core_reset,
    input wire logic        vector_fetch,
    input wire logic [15:0] vector_addr,
    input wire logic [1:0]  reset_phase
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic   in_dly = reset_phase == CSRS_DELAY;
    logic [12:0] dly_n;
    // Counts the cycles spent in the delay phase.
    always_ff @(posedge mclk) begin
        dly_n <= in_dly ? dly_n + 13'h1 : 13'h0;
    end
    // Both vector halves in turn.
    sequence s_vec;
        vector_addr == CSRS_VEC_LO ##1 vector_fetch && vector_addr == CSRS_VEC_HI;
    endsequence
    // Eight cycles of pin drive.
    sequence s_hold8;
        reset_pin_oe [*8];
    endsequence
    property p_oe_dly; in_dly |-> reset_pin_oe; endproperty
    a_oe_dly: assert property (p_oe_dly) else $error("pin released in delay");
    property p_fetch; $rose(vector_fetch) |-> s_vec ##1 !vector_fetch && !core_reset; endproperty
    a_fetch: assert property (p_fetch) else $error("bad vector fetch");
    property p_order; in_dly && !$past(in_dly) |-> $past(reset_phase) == CSRS_ACTIVE; endproperty
    a_order: assert property (p_order) else $error("delay not after active");
    property p_dly_len;
        reset_phase == CSRS_FETCH && $past(in_dly)
            |-> $past(dly_n) == (cfg_long_delay ? CSRS_LONG_LAST : CSRS_SHORT_LAST);
    endproperty
    a_dly_len: assert property (p_dly_len) else $error("delay length wrong");
    property p_lvd; low_voltage_detector |=> reset_pin_oe && core_reset; endproperty
    a_lvd: assert property (p_lvd) else $error("low voltage not held");
    property p_wdg; $rose(watchdog_underflow) |=> s_hold8 ##1 s_hold8; endproperty
    a_wdg: assert property (p_wdg) else $error("watchdog pulse short");
    property p_osc; osc_run && osc_select == cfg_clk_source; endproperty
    a_osc: assert property (p_osc) else $error("oscillator select wrong");
    property p_dbl; doubler_active == (cfg_doubler_en && cfg_clk_source != CSRS_SRC_RC); endproperty
    a_dbl: assert property (p_dbl) else $error("doubler enable wrong");
endmodule
bind csrs_top csrs_monitor u_mon (.mclk, .rst, .cfg_clk_source, .cfg_doubler_en,
    .cfg_long_delay, .doubler_active, .osc_run, .osc_select, .low_voltage_detector,
    .watchdog_underflow, .reset_pin_oe, .core_reset, .vector_fetch, .vector_addr,
    .reset_phase);
`default_nettype wire

//--- csrs_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Board side of the reset pin.
// ****
module csrs_partner (
    // Device drive and board pull.
    input wire logic reset_pin_oe,
    input wire logic ext_pull,
    // Wired pin level.
    output logic     reset_pin_in
);
    // Weak pull-up wins only when nobody drives low.
    assign reset_pin_in = !(reset_pin_oe || ext_pull);
endmodule
`default_nettype wire

//--- csrs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Sequencer bench.
// ****
module csrs_tb_top
    import csrs_pkg::*;
;
    logic        mclk = 0, rst = 1, cfg_doubler_en = 0, cfg_long_delay = 0;
    logic [2:0]  cfg_clk_source = CSRS_SRC_XTAL0;
    logic        source_clock_tick = 0, doubler_clock_tick = 0, ext_pull = 0;
    logic        low_voltage_detector = 0, watchdog_underflow = 0;
    wire logic   reset_pin_in;
    logic        internal_clock_en, doubler_active, osc_run, reset_pin_out, reset_pin_oe;
    logic        core_reset, vector_fetch;
    logic [2:0]  osc_select;
    logic [15:0] vector_addr;
    logic [1:0]  reset_phase;
    int          n_mismatch = 0, n_checks = 0;
    csrs_top dut (.*);
    csrs_partner u_pin (.*);
    // Free-running clock and a hang guard.
    initial forever #20 mclk = ~mclk;
    initial begin
        #1000000;
        n_mismatch++;
        final_report();
    end
    // Compares one value and counts it.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Follows one sequence from the delay start to run.
    task automatic seq_chk;
        int n;
        n = 0;
        while (reset_phase !== CSRS_DELAY && n < 50) begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        while (reset_phase === CSRS_DELAY && n < 5000) begin
            chk("pin_oe", 16'h1, 16'(reset_pin_oe));
            @(negedge mclk);
            n++;
        end
        chk("dly_len", 16'(cfg_long_delay ? CSRS_LONG_DELAY : CSRS_SHORT_DELAY), 16'(n));
        chk("vec_lo", CSRS_VEC_LO, vector_addr);
        @(negedge mclk);
        chk("vec_hi", CSRS_VEC_HI, vector_addr);
        @(negedge mclk);
        chk("run", 16'h0, 16'(core_reset));
        chk("pin_out", 16'h0, 16'(reset_pin_out));
    endtask
    // Low-voltage hold, then a restart in mid-delay.
    task automatic t_lvd;
        low_voltage_detector = 1'b1;
        repeat (20) @(negedge mclk);
        chk("lvd_phase", 16'(CSRS_ACTIVE), 16'(reset_phase));
        chk("lvd_pin", 16'h0, 16'(reset_pin_in));
        low_voltage_detector = 1'b0;
        repeat (30) @(negedge mclk);
        low_voltage_detector = 1'b1;
        @(negedge mclk);
        low_voltage_detector = 1'b0;
        chk("restart", 16'(CSRS_ACTIVE), 16'(reset_phase));
        seq_chk();
    endtask
    // Watchdog pulse with the long delay.
    task automatic t_wdg;
        cfg_long_delay = 1'b1;
        watchdog_underflow = 1'b1;
        @(negedge mclk);
        watchdog_underflow = 1'b0;
        repeat (CSRS_WDG_PULSE - 1) begin
            @(negedge mclk);
            chk("wdg_pin", 16'h0, 16'(reset_pin_in));
            chk("wdg_phase", 16'(CSRS_ACTIVE), 16'(reset_phase));
        end
        seq_chk();
        cfg_long_delay = 1'b0;
    endtask
    // Board pulls the pin for three cycles.
    task automatic t_pin;
        ext_pull = 1'b1;
        repeat (3) @(negedge mclk);
        ext_pull = 1'b0;
        chk("pin_phase", 16'(CSRS_ACTIVE), 16'(reset_phase));
        seq_chk();
    endtask
    // Every source with and without the doubler.
    task automatic t_clk;
        int n;
        for (int i = 0; i < 12; i++) begin
            @(negedge mclk);
            cfg_clk_source = 3'(i >> 1);
            cfg_doubler_en = i[0];
            #1;
            chk("dbl_act", 16'(i[0] && 3'(i >> 1) != CSRS_SRC_RC), 16'(doubler_active));
            chk("osc_sel", 16'(i >> 1), 16'(osc_select));
            chk("osc_run", 16'h1, 16'(osc_run));
        end
        cfg_clk_source = CSRS_SRC_XTAL0;
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            doubler_clock_tick = i[0];
            #1;
            chk("dbl_clk", 16'(i[0]), 16'(internal_clock_en));
        end
        n = 0;
        cfg_doubler_en = 1'b0;
        source_clock_tick = 1'b1;
        repeat (8) begin
            @(negedge mclk);
            n += int'(internal_clock_en === 1'b1);
        end
        source_clock_tick = 1'b0;
        chk("div_clk", 16'h4, 16'(n));
    endtask
    // Main sequence.
    initial begin
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        seq_chk();
        t_lvd();
        t_wdg();
        t_pin();
        t_clk();
        final_report();
    end
endmodule
`default_nettype wire
